// ### src/bdms_alu.sv
// Adder and logic unit producing the result and its arithmetic flags
`timescale 1ns/1ps
module bdms_alu
	import bdms_pkg::*;
(
	input wire bdms_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	output logic [7:0] result,
	output logic zero,
	output logic nibble_carry,
	output logic carry,
	output logic carry_valid
);

	logic [7:0] addend;
	logic cin;
	logic [8:0] sum;
	logic [4:0] low_sum;

	// Subtraction adds the complement plus one, so carry high means no borrow
	always_comb begin
		addend = (op == BDMS_OP_SUB) ? ~b : b;
		cin = (op == BDMS_OP_SUB);
		sum = {1'h0, a} + {1'h0, addend} + {8'h00, cin};
		low_sum = {1'h0, a[3:0]} + {1'h0, addend[3:0]} + {4'h0, cin};
		carry_valid = (op == BDMS_OP_ADD) || (op == BDMS_OP_SUB);
		unique case (op)
			BDMS_OP_ADD, BDMS_OP_SUB: result = sum[7:0];
			BDMS_OP_AND: result = a & b;
			BDMS_OP_XOR: result = a ^ b;
		endcase
		zero = (result == 8'h00);
		nibble_carry = low_sum[4];
		carry = sum[8];
	end

endmodule : bdms_alu

// ### src/bdms_pkg.sv
// Types shared by the banked data memory block
package bdms_pkg;

	// Which storage an address lands in
	typedef enum logic [2:0] {
		BDMS_RG_NONE = 3'h0,
		BDMS_RG_CORE = 3'h1,
		BDMS_RG_PERIPH = 3'h3,
		BDMS_RG_RAM = 3'h2
	} bdms_region_t;

	// Operations of the datapath that touch the flags
	typedef enum logic [1:0] {
		BDMS_OP_ADD = 2'h0,
		BDMS_OP_SUB = 2'h1,
		BDMS_OP_AND = 2'h3,
		BDMS_OP_XOR = 2'h2
	} bdms_op_t;

	// Result of an address decode
	typedef struct packed {
		bdms_region_t region;
		logic [7:0] idx;
	} bdms_decode_t;

endpackage : bdms_pkg

// ### src/bdms_ram.sv
// 256-byte store for general RAM of banks 0-2 and the common RAM
`timescale 1ns/1ps
module bdms_ram
	import bdms_pkg::*;
(
	input wire logic sys_clk,
	bdms_ram_if.store mem
);

	logic [7:0] cells [0:255];

	// Write port; contents are not cleared, like real SRAM
	always_ff @(posedge sys_clk) begin
		if (mem.we) begin
			cells[mem.addr] <= mem.wdata;
		end
	end

	// Registered read keeps the output timing clean
	always_ff @(posedge sys_clk) begin
		mem.rdata <= cells[mem.addr];
	end

endmodule : bdms_ram

// ### src/bdms_ram_if.sv
// Port bundle between the register file and its byte memory
`timescale 1ns/1ps
interface bdms_ram_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;

	modport owner (output addr, output wdata, output we, input rdata);
	modport store (input addr, input wdata, input we, output rdata);
endinterface : bdms_ram_if

// ### src/bdms_regs.svh
// Address map, field positions, reset values and rule overview of the banked data memory block
//
// Overview of operation
// - Expiry flag reads 1 after power-up, kick or sleep; 0 after watchdog timeout.
// - Sleep flag reads 1 after power-up or kick; 0 after sleep instruction.
// - Zero flag set on zero arithmetic or logic result, cleared on nonzero.
// - Add and subtract set nibble carry on carry out of bit 3.
// - Add and subtract set carry on carry out of bit 7.
// - During subtraction both carry flags read 0 when a borrow occurred.
// - Subtraction adds the two's complement of operand two; flags come from that sum.
// - Status bits 7 to 5 always read 0.
// - Power-on reset: expiry and sleep flags 1, arithmetic 0; other resets by condition.
// - Offsets 0x0C to 0x1F of each bank form the peripheral register area.
// - At most 80 bytes of general RAM per bank, after the peripheral area.
// - General RAM also reachable unbanked as one contiguous linear space.
// - Sixteen bytes of common RAM reachable from any selected bank.
// - Common RAM lives at 0x70-0x7F of bank 0; other banks alias it.
// - Banks 0, 1 and 2 hold 80-byte general RAM at offsets 0x20-0x6F.
// - Offsets 0x00 to 0x0B of each bank reach the core register set.
// - Every unimplemented location, including absent general RAM, reads 0.
// - Core registers are the same physical registers from every bank.
// - Addresses are 12 bits: five bank bits, seven offset bits.
`ifndef BDMS_REGS_SVH
`define BDMS_REGS_SVH

// ****************************************************************
// Bus windows
// ****************************************************************
`define BDMS_BANKED_TOP 16'h0FFF
`define BDMS_DIRECT_BASE 16'h1000
`define BDMS_DIRECT_TOP 16'h107F
`define BDMS_LINEAR_BASE 16'h2000
`define BDMS_LINEAR_BYTES 16'h00F0

// ****************************************************************
// Offsets inside a bank
// ****************************************************************
`define BDMS_CORE_LAST 7'h0B
`define BDMS_PERIPH_LAST 7'h1F
`define BDMS_GRAM_FIRST 7'h20
`define BDMS_GRAM_LAST 7'h6F
`define BDMS_COMMON_FIRST 7'h70
`define BDMS_GRAM_BANKS 5'h03
`define BDMS_GRAM_BYTES 8'h50
`define BDMS_COMMON_BASE 8'hF0
`define BDMS_CORE_STATUS 4'h3
`define BDMS_CORE_BANKSEL 4'h8
`define BDMS_CORE_COUNT 12

// ****************************************************************
// Status fields and reset values
// ****************************************************************
`define BDMS_ST_EXPIRY 4
`define BDMS_ST_SLEEP 3
`define BDMS_ST_ZERO 2
`define BDMS_ST_NIBBLE 1
`define BDMS_ST_CARRY 0
`define BDMS_ST_FLAG_RESET 1'h1
`define BDMS_ST_ARITH_RESET 1'h0

`endif

// ### src/bdms_top.sv
// Banked data memory with core registers, status flags and an Avalon-MM register port
`timescale 1ns/1ps
`include "bdms_regs.svh"
module bdms_top
	import bdms_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [7:0] avs_writedata,
	output logic [7:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic alu_valid,
	input wire bdms_op_t alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	output logic [7:0] alu_result,
	input wire logic watchdog_kick_instr,
	input wire logic sleep_instr,
	input wire logic watchdog_timeout,
	input wire logic other_reset,
	input wire logic other_reset_by_watchdog,
	output logic [7:0] status_value,
	output logic [4:0] bank_select_value
);

	// ****************************************************************
	// Storage
	// ****************************************************************

	logic watchdog_expiry_flag;
	logic sleep_entered_flag;
	logic zero_flag;
	logic nibble_carry_flag;
	logic carry_flag;
	logic [7:0] core_mem [0:`BDMS_CORE_COUNT-1];
	logic rd_phase;
	logic rd_from_ram;
	logic [7:0] reg_rdata;

	bdms_decode_t dec;
	logic wr_req;
	logic rd_start;
	logic [7:0] status_read;
	logic [7:0] alu_res_c;
	logic alu_zero_c;
	logic alu_nib_c;
	logic alu_carry_c;
	logic alu_carry_valid_c;
	logic st_wr;
	logic bsel_wr;
	logic core_wr;
	logic ram_wr;

	// Bundle to the byte store; the store owns only its read register
	bdms_ram_if ram_bus ();

	// ****************************************************************
	// Address decode
	// ****************************************************************

	// Three bus windows: banked addresses as the core forms them,
	// a direct window on the live bank select, and an unbanked run over general RAM.
	// Anything else decodes to nothing and reads as zero, so stray accesses are harmless.

	// Store index of a banked general RAM byte; the banks follow one another
	function automatic logic [7:0] gram_index(input logic [4:0] bank, input logic [6:0] off);
		return 8'({3'h0, bank} * `BDMS_GRAM_BYTES) + 8'({1'h0, off - `BDMS_GRAM_FIRST});
	endfunction : gram_index

	// Split a 12-bit data address into bank and offset and classify it
	function automatic bdms_decode_t decode_banked(input logic [11:0] data_addr);
		logic [4:0] bank;
		logic [6:0] off;
		logic [7:0] gram_idx;
		bdms_decode_t d;
		bank = data_addr[11:7];
		off = data_addr[6:0];
		gram_idx = gram_index(bank, off);
		d.region = BDMS_RG_NONE;
		d.idx = 8'h00;
		if (off <= `BDMS_CORE_LAST) begin
			// Same physical register whatever the bank
			d.region = BDMS_RG_CORE;
			d.idx = {4'h0, off[3:0]};
		end else if (off <= `BDMS_PERIPH_LAST) begin
			d.region = BDMS_RG_PERIPH;
			d.idx = {1'h0, off};
		end else if (off <= `BDMS_GRAM_LAST) begin
			if (bank < `BDMS_GRAM_BANKS) begin
				d.region = BDMS_RG_RAM;
				d.idx = gram_idx;
			end
		end else begin
			// Every bank reaches the bytes that bank 0 holds
			d.region = BDMS_RG_RAM;
			d.idx = `BDMS_COMMON_BASE + {4'h0, off[3:0]};
		end
		return d;
	endfunction : decode_banked

	// Direct file access forms the address from bank select and offset
	function automatic logic [11:0] direct_addr(input logic [4:0] bsel, input logic [6:0] off);
		return {bsel, off};
	endfunction : direct_addr

	// Map any bus address onto storage
	function automatic bdms_decode_t decode_bus(input logic [15:0] a, input logic [4:0] bsel);
		logic [15:0] lin;
		bdms_decode_t d;
		lin = a - `BDMS_LINEAR_BASE;
		d.region = BDMS_RG_NONE;
		d.idx = 8'h00;
		if (a <= `BDMS_BANKED_TOP) begin
			d = decode_banked(a[11:0]);
		end else if (a >= `BDMS_DIRECT_BASE && a <= `BDMS_DIRECT_TOP) begin
			d = decode_banked(direct_addr(bsel, a[6:0]));
		end else if (a >= `BDMS_LINEAR_BASE && lin < `BDMS_LINEAR_BYTES) begin
			// Banks 0-2 general RAM laid end to end, no bank gaps
			d.region = BDMS_RG_RAM;
			d.idx = lin[7:0];
		end
		return d;
	endfunction : decode_bus

	// Decode follows the held bus address with no storage
	always_comb begin
		dec = decode_bus(avs_address, bank_select_value);
	end

	// True when a decode lands on one particular core register
	function automatic logic core_hit(input bdms_decode_t d, input logic [3:0] which);
		return (d.region == BDMS_RG_CORE) && (d.idx[3:0] == which);
	endfunction : core_hit

	// Write strobes per target; peripheral and unmapped writes fall through and are lost
	always_comb begin
		st_wr = wr_req && core_hit(dec, `BDMS_CORE_STATUS);
		bsel_wr = wr_req && core_hit(dec, `BDMS_CORE_BANKSEL);
		core_wr = wr_req && (dec.region == BDMS_RG_CORE);
		ram_wr = wr_req && (dec.region == BDMS_RG_RAM);
	end

	// ****************************************************************
	// Bus handshake
	// ****************************************************************

	// Reads stall one cycle for the registered memory; writes never stall
	// A read dropped before its second cycle is simply abandoned
	always_comb begin
		avs_waitrequest = avs_read && !rd_phase;
		rd_start = avs_read && !rd_phase;
	end

	// A write lands at the edge where it is first seen
	always_comb begin
		wr_req = avs_write;
	end

	// Second cycle of a read presents registered data
	// Cleared by the same edge that hands the data over, so reads may follow back to back
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_phase <= 1'h0;
		end else begin
			rd_phase <= rd_start;
		end
	end

	// ****************************************************************
	// Flag datapath
	// ****************************************************************

	// Flag logic lives beside the adder so carries come from the very sum that is stored
	bdms_alu u_alu (
		.op(alu_op),
		.a(alu_a),
		.b(alu_b),
		.result(alu_res_c),
		.zero(alu_zero_c),
		.nibble_carry(alu_nib_c),
		.carry(alu_carry_c),
		.carry_valid(alu_carry_valid_c)
	);

	// Result is held for the datapath to pick up
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			alu_result <= 8'h00;
		end else if (alu_valid) begin
			alu_result <= alu_res_c;
		end
	end

	// Watchdog expiry flag; a timeout beats a kick in the same cycle so it is never lost
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			watchdog_expiry_flag <= `BDMS_ST_FLAG_RESET;
		end else if (watchdog_timeout) begin
			watchdog_expiry_flag <= 1'h0;
		end else if (other_reset) begin
			watchdog_expiry_flag <= !other_reset_by_watchdog;
		end else if (watchdog_kick_instr || sleep_instr) begin
			watchdog_expiry_flag <= 1'h1;
		end
	end

	// Sleep flag; software cannot write it
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sleep_entered_flag <= `BDMS_ST_FLAG_RESET;
		end else if (sleep_instr) begin
			sleep_entered_flag <= 1'h0;
		end else if (watchdog_kick_instr) begin
			sleep_entered_flag <= 1'h1;
		end
	end

	// Zero flag: an instruction that sets it overrides a store to the status byte
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			zero_flag <= `BDMS_ST_ARITH_RESET;
		end else if (alu_valid) begin
			zero_flag <= alu_zero_c;
		end else if (st_wr) begin
			zero_flag <= avs_writedata[`BDMS_ST_ZERO];
		end
	end

	// Nibble carry: logic operations leave it alone, so a store in that cycle still lands
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			nibble_carry_flag <= `BDMS_ST_ARITH_RESET;
		end else if (alu_valid && alu_carry_valid_c) begin
			nibble_carry_flag <= alu_nib_c;
		end else if (st_wr) begin
			nibble_carry_flag <= avs_writedata[`BDMS_ST_NIBBLE];
		end
	end

	// Carry: set after a subtraction means that no borrow was needed
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			carry_flag <= `BDMS_ST_ARITH_RESET;
		end else if (alu_valid && alu_carry_valid_c) begin
			carry_flag <= alu_carry_c;
		end else if (st_wr) begin
			carry_flag <= avs_writedata[`BDMS_ST_CARRY];
		end
	end

	// Upper three bits are not implemented
	always_comb begin
		status_read = 8'h00;
		status_read[`BDMS_ST_EXPIRY] = watchdog_expiry_flag;
		status_read[`BDMS_ST_SLEEP] = sleep_entered_flag;
		status_read[`BDMS_ST_ZERO] = zero_flag;
		status_read[`BDMS_ST_NIBBLE] = nibble_carry_flag;
		status_read[`BDMS_ST_CARRY] = carry_flag;
		status_value = status_read;
	end

	// ****************************************************************
	// Core registers
	// ****************************************************************

	// Bank select steers the direct window; only five bits exist
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bank_select_value <= 5'h00;
		end else if (bsel_wr) begin
			bank_select_value <= avs_writedata[4:0];
		end
	end

	// Plain byte storage for the remaining core registers, shared by all banks
	// Status and bank select bytes here are shadow copies that no read returns
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < `BDMS_CORE_COUNT; i++) begin
				core_mem[i] <= 8'h00;
			end
		end else if (core_wr) begin
			core_mem[dec.idx[3:0]] <= avs_writedata;
		end
	end

	// ****************************************************************
	// Memory and read path
	// ****************************************************************

	// The store sees every decoded address, so read data follow one clock later
	always_comb begin
		ram_bus.addr = dec.idx;
		ram_bus.wdata = avs_writedata;
		ram_bus.we = ram_wr;
	end

	// Banked, direct and linear views all share this one store, so no copies exist
	bdms_ram u_ram (
		.sys_clk(sys_clk),
		.mem(ram_bus)
	);

	// Remember which source answers, since the address may move once the read is taken
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_from_ram <= 1'h0;
		end else if (rd_start) begin
			rd_from_ram <= (dec.region == BDMS_RG_RAM);
		end
	end

	// Non-memory read data is captured in the first read cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (rd_start) begin
			unique case (dec.region)
				BDMS_RG_CORE: begin
					if (dec.idx[3:0] == `BDMS_CORE_STATUS) begin
						reg_rdata <= status_read;
					end else if (dec.idx[3:0] == `BDMS_CORE_BANKSEL) begin
						reg_rdata <= {3'h0, bank_select_value};
					end else begin
						reg_rdata <= core_mem[dec.idx[3:0]];
					end
				end
				// No peripherals live here, so the area reads as empty
				BDMS_RG_PERIPH: reg_rdata <= 8'h00;
				BDMS_RG_RAM: reg_rdata <= 8'h00;
				BDMS_RG_NONE: reg_rdata <= 8'h00;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Both sources are flip-flops; the mux only picks one
	always_comb begin
		avs_readdata = rd_from_ram ? ram_bus.rdata : reg_rdata;
	end

endmodule : bdms_top

// ### tb/bdms_chk.sv
// Port assertions for the banked data memory
`timescale 1ns/1ps
module bdms_chk
	import bdms_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] avs_address,
	input wire logic avs_write,
	input wire logic [7:0] avs_writedata,
	input wire logic alu_valid,
	input wire bdms_op_t alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic [7:0] alu_result,
	input wire logic watchdog_kick_instr,
	input wire logic sleep_instr,
	input wire logic watchdog_timeout,
	input wire logic other_reset,
	input wire logic other_reset_by_watchdog,
	input wire logic [7:0] status_value,
	input wire logic [4:0] bank_select_value
);
	logic [8:0] sum_add;
	logic [8:0] sum_sub;
	logic [4:0] nib;
	logic [7:0] res_exp;

	// Subtraction is an add of the inverted operand plus one, so carries come from that sum
	assign sum_add = {1'h0, alu_a} + {1'h0, alu_b};
	assign sum_sub = {1'h0, alu_a} + {1'h0, ~alu_b} + 9'h001;
	assign nib = (alu_op == BDMS_OP_SUB) ? {1'h0, alu_a[3:0]} + {1'h0, ~alu_b[3:0]} + 5'h01
		: {1'h0, alu_a[3:0]} + {1'h0, alu_b[3:0]};
	// Expected result from the operands alone, so the zero check does not lean on the design
	assign res_exp = (alu_op == BDMS_OP_ADD) ? sum_add[7:0] : (alu_op == BDMS_OP_SUB) ? sum_sub[7:0]
		: (alu_op == BDMS_OP_AND) ? (alu_a & alu_b) : (alu_a ^ alu_b);

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// ****************************************
	// Status and bank select
	// ****************************************
	chk_top_zero: assert property (status_value[7:5] == 3'h0)
		else $error("status top bits set");
	chk_timeout_clr: assert property (watchdog_timeout |=> !status_value[4])
		else $error("expiry flag not cleared");
	chk_sleep_flags: assert property (sleep_instr && !watchdog_timeout && !watchdog_kick_instr
		|=> status_value[4:3] == 2'h2) else $error("sleep flags wrong");
	chk_kick_flags: assert property (watchdog_kick_instr && !watchdog_timeout && !sleep_instr
		|=> status_value[4:3] == 2'h3) else $error("kick flags wrong");
	chk_other_rst: assert property (other_reset && !watchdog_timeout && !watchdog_kick_instr && !sleep_instr
		&& !alu_valid && !avs_write |=> status_value[4] == !$past(other_reset_by_watchdog)
		&& $stable(status_value[3:0])) else $error("other reset flags wrong");
	chk_add_carry: assert property (alu_valid && alu_op == BDMS_OP_ADD
		|=> status_value[1:0] == {$past(nib[4]), $past(sum_add[8])}) else $error("add carries wrong");
	chk_sub_borrow: assert property (alu_valid && alu_op == BDMS_OP_SUB
		|=> status_value[1:0] == {$past(nib[4]), $past(sum_sub[8])}) else $error("sub borrows wrong");
	chk_zero_flag: assert property (alu_valid |=> status_value[2] == ($past(res_exp) == 8'h00)
		&& alu_result == $past(res_exp)) else $error("zero flag or result wrong");
	chk_bank_sel: assert property (avs_write && avs_address[15:12] == 4'h0 && avs_address[6:0] == 7'h08
		|=> bank_select_value == $past(avs_writedata[4:0])) else $error("bank select not written");
endmodule : bdms_chk

// ### tb/tb.sv
// Self-checking bench for the banked data memory
`timescale 1ns/1ps
module tb
	import bdms_pkg::*;
;
	logic sys_clk;
	logic rst_n;
	logic [15:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [7:0] avs_writedata;
	logic [7:0] avs_readdata;
	logic avs_waitrequest;
	logic alu_valid;
	bdms_op_t alu_op;
	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic [7:0] alu_result;
	logic watchdog_kick_instr;
	logic sleep_instr;
	logic watchdog_timeout;
	logic other_reset;
	logic other_reset_by_watchdog;
	logic [7:0] status_value;
	logic [4:0] bank_select_value;
	int num_errors;
	int n_checks;
	logic [15:0] seed;
	logic [7:0] mdl [int];
	logic [4:0] evs [7] = '{5'h08, 5'h10, 5'h04, 5'h10, 5'h03, 5'h02, 5'h0C};

	bdms_top bdms_top_inst (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .alu_valid, .alu_op, .alu_a, .alu_b, .alu_result,
		.watchdog_kick_instr, .sleep_instr, .watchdog_timeout, .other_reset, .other_reset_by_watchdog,
		.status_value, .bank_select_value);

	// Free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Model and helpers
	// ****************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Byte reached by an address: -1 reads 0, 1000 up core, else store index
	function automatic int key_of(input logic [15:0] a);
		int b;
		int o;
		b = int'(a[11:7]);
		o = int'(a[6:0]);
		if (a[15:7] == 9'h020) b = int'(mdl[1008][4:0]);
		else if (a[15:8] == 8'h20) return (a[7:0] < 8'hF0) ? int'(a[7:0]) : -1;
		else if (a[15:12] != 4'h0) return -1;
		if (o < 12) return 1000 + o;
		if (o < 32) return -1;
		if (o >= 112) return o + 128;
		return (b < 3) ? b * 80 + o - 32 : -1;
	endfunction : key_of

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// Held bus cycle; the model is updated or compared at the taking edge
	task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
		int n;
		int k;
		logic [7:0] q;
		k = key_of(a);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			wrap_up();
		end
		// Flags at bits 4 and 3 are read-only, so a write keeps them
		if (wr && k == 1003) mdl[k] = {3'h0, mdl[k][4:3], d[2:0]};
		else if (wr && k == 1008) mdl[k] = {3'h0, d[4:0]};
		else if (wr && k >= 0) mdl[k] = d;
		else if (!wr && k < 0) chk8(q, 8'h00);
		else if (!wr && mdl.exists(k)) chk8(q, mdl[k]);
	endtask : bus

	task automatic alu(input bdms_op_t op, input logic [7:0] a, input logic [7:0] b);
		int r;
		int h;
		logic [7:0] s;
		@(posedge sys_clk);
		alu_valid <= 1'b1;
		alu_op <= op;
		alu_a <= a;
		alu_b <= b;
		@(posedge sys_clk);
		alu_valid <= 1'b0;
		s = mdl[1003];
		r = (op == BDMS_OP_ADD) ? a + b : (op == BDMS_OP_SUB) ? a + (255 - b) + 1 : 0;
		h = (op == BDMS_OP_ADD) ? (a & 15) + (b & 15) : (a & 15) + (15 - (b & 15)) + 1;
		if (op == BDMS_OP_AND) r = a & b;
		if (op == BDMS_OP_XOR) r = a ^ b;
		if (op == BDMS_OP_ADD || op == BDMS_OP_SUB) s[1:0] = {h > 15, r > 255};
		s[2] = (r % 256) == 0;
		mdl[1003] = s;
		@(negedge sys_clk);
		chk8(alu_result, r[7:0]);
		chk8(status_value, s);
	endtask : alu

	// One cycle of watchdog, sleep and reset-cause pulses: {kick, sleep, timeout, other, by_watchdog}
	task automatic ev(input logic [4:0] v);
		logic [7:0] s;
		@(posedge sys_clk);
		{watchdog_kick_instr, sleep_instr, watchdog_timeout, other_reset, other_reset_by_watchdog} <= v;
		@(posedge sys_clk);
		{watchdog_kick_instr, sleep_instr, watchdog_timeout, other_reset, other_reset_by_watchdog} <= 5'h00;
		s = mdl[1003];
		if (v[4]) s[4:3] = 2'h3;
		if (v[3]) s[4:3] = 2'h2;
		if (v[1]) s[4] = !v[0];
		if (v[2]) s[4] = 1'b0;
		mdl[1003] = s;
		@(negedge sys_clk);
		chk8(status_value, s);
	endtask : ev

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [15:0] a;
		{rst_n, avs_read, avs_write, alu_valid, avs_address, avs_writedata, alu_a, alu_b} = 44'h0;
		{watchdog_kick_instr, sleep_instr, watchdog_timeout, other_reset, other_reset_by_watchdog} = 5'h00;
		alu_op = BDMS_OP_ADD;
		{num_errors, n_checks, seed} = {32'h0, 32'h0, 16'h0040};
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		mdl[1003] = 8'h18;
		mdl[1008] = 8'h00;
		bus(1'b0, 16'h0003, 8'h00);
		// Fill general RAM linearly, one past the end, then common RAM through bank 5
		for (int i = 0; i < 241; i++) begin
			seed = lfsr(seed);
			bus(1'b1, 16'h2000 | i[7:0], seed[7:0]);
		end
		for (int i = 0; i < 16; i++) bus(1'b1, 16'h02F0 | i[3:0], 8'hA0 | i[3:0]);
		// Random mix of banked, direct, linear and unmapped traffic
		for (int i = 0; i < 500; i++) begin
			seed = lfsr(seed);
			a = {4'h0, seed[11:0]};
			if (seed[15:13] == 3'h0) a = {9'h020, seed[6:0]};
			if (seed[15:13] == 3'h1) a = {8'h20, seed[7:0]};
			if (seed[15:13] == 3'h7) a = {4'h5, seed[11:0]};
			seed = lfsr(seed);
			bus(seed[15] & seed[14], a, seed[7:0]);
		end
		alu(BDMS_OP_ADD, 8'h0F, 8'h01);
		alu(BDMS_OP_ADD, 8'hFF, 8'h01);
		alu(BDMS_OP_SUB, 8'h05, 8'h05);
		alu(BDMS_OP_SUB, 8'h10, 8'h01);
		alu(BDMS_OP_SUB, 8'h00, 8'h01);
		alu(BDMS_OP_AND, 8'hF0, 8'h0F);
		for (int i = 0; i < 40; i++) begin
			seed = lfsr(seed);
			alu(bdms_op_t'(seed[1:0]), seed[15:8], seed[7:0]);
		end
		foreach (evs[j]) ev(evs[j]);
		bus(1'b1, 16'h0F83, 8'hFF);
		bus(1'b0, 16'h0083, 8'h00);
		// Reset again in mid-run
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 1000; i < 1012; i++) mdl.delete(i);
		mdl[1003] = 8'h18;
		mdl[1008] = 8'h00;
		@(negedge sys_clk);
		chk8(status_value, 8'h18);
		chk8({3'h0, bank_select_value}, 8'h00);
		// General RAM keeps its contents across reset; status reads back its reset value
		bus(1'b0, 16'h2000, 8'h00);
		bus(1'b0, 16'h0003, 8'h00);
		wrap_up();
	end
endmodule : tb

bind bdms_top bdms_chk bdms_chk_inst (.sys_clk, .rst_n, .avs_address, .avs_write, .avs_writedata,
	.alu_valid, .alu_op, .alu_a, .alu_b, .alu_result, .watchdog_kick_instr, .sleep_instr, .watchdog_timeout,
	.other_reset, .other_reset_by_watchdog, .status_value, .bank_select_value);
